/* shared/pasl_map.svh */
`ifndef PASL_MAP_SVH
`define PASL_MAP_SVH

// ----------------------------------------------------------------------------
// Pin group size
// ----------------------------------------------------------------------------
`define PASL_PIN_CNT        5

// ----------------------------------------------------------------------------
// Address bit carried by each shared pin
// ----------------------------------------------------------------------------
`define PASL_BIT_ACT        0
`define PASL_BIT_COL        1
`define PASL_BIT_LINK       2
`define PASL_BIT_TX         3
`define PASL_BIT_RX         4

// ----------------------------------------------------------------------------
// Reset values and the drive-phase enable
// ----------------------------------------------------------------------------
`define PASL_RST_ADDR       5'h0_0
`define PASL_RST_PIN_OUT    5'h0_0
`define PASL_RST_PIN_OE     5'h0_0
`define PASL_ALL_OE         5'h1_F

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PASL_CLK_HZ         64'h0000_0000_017D_7840
`define PASL_COL_HOLD_MS    64'h0000_0000_0000_0046
`define PASL_MS_PER_S       64'h0000_0000_0000_03E8
// Longest hold rounds down to whole cycles
`define PASL_COL_HOLD_CYC   ((`PASL_COL_HOLD_MS * `PASL_CLK_HZ) / `PASL_MS_PER_S)

`endif

/* shared/pasl_pkg.sv */
package pasl_pkg;

  // --------------------------------------------------------------------------
  // Pin phase
  // --------------------------------------------------------------------------
  typedef enum logic {
    PASL_PH_STRAP,                // Pins are inputs, waiting to sample
    PASL_PH_DRIVE                 // Pins drive status indicators
  } pasl_phase_e;

  // --------------------------------------------------------------------------
  // Status indications, packed in address bit order
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rx;                     // Bit 4: receive activity
    logic tx;                     // Bit 3: transmit activity
    logic link;                   // Bit 2: valid link
    logic col;                    // Bit 1: stretched collision
    logic act;                    // Bit 0: receive or transmit activity
  } pasl_ind_s;

endpackage : pasl_pkg

/* rtl/pasl_stretch.sv */
`timescale 1ns/1ps

`include "pasl_map.svh"

// Retriggerable pulse stretcher: busy stays high for HOLD_CYC cycles
// after the last trigger.
module pasl_stretch
  import pasl_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 32'(`PASL_COL_HOLD_CYC), // Hold length in cycles
  parameter int unsigned CW       = $clog2(HOLD_CYC + 1) // Counter width
) (
  input  wire logic mclk,         // Block clock
  input  wire logic arst_n,       // Asynchronous reset, active low
  input  wire logic trig,         // Event to stretch
  output logic      busy          // Stretched indication
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("pasl_stretch: HOLD_CYC must be at least one");
  end
  if (CW < $clog2(HOLD_CYC + 1)) begin : g_bad_cw
    $error("pasl_stretch: CW too narrow for HOLD_CYC");
  end

  localparam logic [CW-1:0] RELOAD = CW'(HOLD_CYC - 1); // Count after trigger
  localparam logic [CW-1:0] ZERO   = '0;                // Empty counter

  logic [CW-1:0] cnt_r;           // Remaining hold cycles
  logic [CW-1:0] cnt_nxt;         // Next count
  logic          busy_r;          // Registered busy
  logic          busy_nxt;        // Next busy
  wire           cnt_done;        // Counter has run out

  // --------------------------------------------------------------------------
  // Next-state decode
  // --------------------------------------------------------------------------
  assign cnt_done = (cnt_r == ZERO);
  // A new event reloads, so a burst keeps the indicator lit
  assign cnt_nxt  = trig ? RELOAD : (cnt_done ? ZERO : cnt_r - CW'(1));
  assign busy_nxt = trig | (busy_r & ~cnt_done);
  assign busy     = busy_r;

  // Counter and flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_trig_loads: assert property (
    @(posedge mclk) disable iff (!arst_n)
    trig |=> busy_r && (cnt_r == RELOAD))
    else $error("stretcher did not load on trigger");

  a_hold_keeps: assert property (
    @(posedge mclk) disable iff (!arst_n)
    // A trigger in the previous cycle reloads instead of counting down
    busy_r && !cnt_done |=> busy_r && ($past(trig) || cnt_r == $past(cnt_r) - CW'(1)))
    else $error("stretcher dropped or miscounted during hold");

  a_hold_ends: assert property (
    @(posedge mclk) disable iff (!arst_n)
    busy_r && cnt_done && !trig |=> !busy_r)
    else $error("stretcher held past its length");

endmodule : pasl_stretch

/* rtl/pasl_top.sv */
`timescale 1ns/1ps

`include "pasl_map.svh"

// Summary of operation
// - Pins are inputs in reset, sampled at release
// - After sampling, all pins drive indicators
// - Software reset leaves pins and address alone
// - Asserted output level inverts the sampled level
// - Low strap gives address zero, high one
// - Pin 0: address bit 0, then activity
// - Pin 1: address bit 1, then collision
// - Collision indication held about 70 ms
// - Pin 2: address bit 2, then link
// - Pin 3: address bit 3, then transmit
// - Pin 4: address bit 4, then receive
module pasl_top
  import pasl_pkg::*;
#(
  parameter int unsigned PIN_CNT     = `PASL_PIN_CNT,      // Shared pins
  parameter int unsigned COL_HOLD_CYC = 32'(`PASL_COL_HOLD_CYC) // Collision hold, cycles
) (
  input  wire logic               mclk,            // 25 MHz block clock
  input  wire logic               arst_n,          // Power-on or hardware reset, low
  input  wire logic               sw_reset,        // Software reset request, high
  input  wire logic               link_up,         // Valid link present
  input  wire logic               tx_act,          // Transmit activity
  input  wire logic               rx_act,          // Receive activity
  input  wire logic               col_det,         // Collision detected
  input  wire logic [PIN_CNT-1:0] pin_in,          // Shared pin levels
  output logic      [PIN_CNT-1:0] pin_out,         // Shared pin drive levels
  output logic      [PIN_CNT-1:0] pin_oe,          // Shared pin drive enables, high
  output logic      [PIN_CNT-1:0] management_station_address // Sampled address
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // The indicator set is fixed at five, one per address bit
  if (PIN_CNT != `PASL_PIN_CNT) begin : g_bad_pins
    $error("pasl_top: PIN_CNT must equal the indicator count");
  end
  if (COL_HOLD_CYC < 1) begin : g_bad_hold
    $error("pasl_top: COL_HOLD_CYC must be at least one");
  end

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  pasl_phase_e        phase_r;        // Strap or drive phase
  pasl_phase_e        phase_nxt;      // Next phase
  logic [PIN_CNT-1:0] strap_r;        // Levels sampled at reset release
  logic [PIN_CNT-1:0] strap_nxt;      // Next sampled levels
  logic [PIN_CNT-1:0] pin_out_r;      // Registered drive levels
  logic [PIN_CNT-1:0] pin_out_nxt;    // Next drive levels
  logic [PIN_CNT-1:0] pin_oe_r;       // Registered drive enables
  logic [PIN_CNT-1:0] pin_oe_nxt;     // Next drive enables
  logic               col_busy;       // Stretched collision
  pasl_ind_s          ind;            // Live indications
  wire  [PIN_CNT-1:0] ind_vec;        // Indications as a vector
  wire                in_strap;       // Strap phase decode
  wire                in_drive;       // Drive phase decode

  // Active level of an indicator pin: the opposite of its strap level
  function automatic logic [PIN_CNT-1:0] led_level(
    input logic [PIN_CNT-1:0] strap,
    input logic [PIN_CNT-1:0] on
  );
    led_level = strap ^ on;
  endfunction : led_level

  // --------------------------------------------------------------------------
  // Collision stretcher
  // --------------------------------------------------------------------------
  // A single collision lasts microseconds, far too short to see on a lamp
  pasl_stretch #(
    .HOLD_CYC (COL_HOLD_CYC),
    .CW       ($clog2(COL_HOLD_CYC + 1))
  ) u_col_stretch (
    .mclk   (mclk),
    .arst_n (arst_n),
    .trig   (col_det),
    .busy   (col_busy)
  );

  // --------------------------------------------------------------------------
  // Indicator mapping, one per address bit
  // --------------------------------------------------------------------------
  always_comb begin
    ind      = '0;
    ind.act  = rx_act | tx_act;
    ind.col  = col_busy;
    ind.link = link_up;
    ind.tx   = tx_act;
    ind.rx   = rx_act;
  end

  assign ind_vec  = ind;
  assign in_strap = (phase_r == PASL_PH_STRAP);
  assign in_drive = (phase_r == PASL_PH_DRIVE);

  // --------------------------------------------------------------------------
  // Phase and next-value selection
  // --------------------------------------------------------------------------
  // Only the asynchronous reset returns the block to the strap phase;
  // software reset is deliberately not a term here
  always_comb begin
    phase_nxt   = phase_r;
    strap_nxt   = strap_r;
    pin_out_nxt = pin_out_r;
    pin_oe_nxt  = pin_oe_r;
    case (phase_r)
      PASL_PH_STRAP: begin
        // First edge after release: sample, then start driving
        phase_nxt   = PASL_PH_DRIVE;
        strap_nxt   = pin_in;
        pin_out_nxt = pin_in;
        pin_oe_nxt  = `PASL_ALL_OE;
      end
      PASL_PH_DRIVE: begin
        // Address frozen; outputs follow the indications
        pin_out_nxt = led_level(strap_r, ind_vec);
        pin_oe_nxt  = `PASL_ALL_OE;
      end
      default: begin
        // Unreachable encoding: fall back to sampling safely
        phase_nxt   = PASL_PH_STRAP;
        pin_oe_nxt  = `PASL_RST_PIN_OE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  // Pins stay undriven throughout reset so the straps can be read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r   <= PASL_PH_STRAP;
      pin_oe_r  <= `PASL_RST_PIN_OE;
      pin_out_r <= `PASL_RST_PIN_OUT;
    end else begin
      phase_r   <= phase_nxt;
      pin_oe_r  <= pin_oe_nxt;
      pin_out_r <= pin_out_nxt;
    end
  end

  // Address register, changed only on the sampling edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_r <= `PASL_RST_ADDR;
    end else begin
      strap_r <= strap_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, straight from flip-flops
  // --------------------------------------------------------------------------
  assign pin_out                    = pin_out_r;
  assign pin_oe                     = pin_oe_r;
  assign management_station_address = strap_r;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_sample;
    in_strap ##1 in_drive;
  endsequence

  sequence s_driving;
    in_drive ##1 in_drive;
  endsequence

  a_strap_undriven: assert property (
    @(posedge mclk) disable iff (!arst_n)
    in_strap |-> pin_oe_r == `PASL_RST_PIN_OE)
    else $error("pins driven during strap phase");

  a_sample_value: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_sample |-> strap_r == $past(pin_in) && pin_out_r == $past(pin_in))
    else $error("address not taken from pin levels at release");

  a_drive_enable: assert property (
    @(posedge mclk) disable iff (!arst_n)
    in_strap |=> in_drive && pin_oe_r == `PASL_ALL_OE)
    else $error("pins not switched to outputs after sampling");

  a_swrst_no_effect: assert property (
    @(posedge mclk) disable iff (!arst_n)
    in_drive && sw_reset |=> in_drive && pin_oe_r == `PASL_ALL_OE && $stable(strap_r))
    else $error("software reset disturbed the shared pins");

  a_led_polarity: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_driving |-> pin_out_r == ($past(strap_r) ^ $past(ind_vec)))
    else $error("pin level not inverted from strap when asserted");

  a_act_pin: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_driving |-> pin_out_r[`PASL_BIT_ACT] ==
      ($past(strap_r[`PASL_BIT_ACT]) ^ ($past(rx_act) | $past(tx_act))))
    else $error("activity pin wrong");

  a_col_pin: assert property (
    @(posedge mclk) disable iff (!arst_n)
    in_drive && col_det ##1 in_drive |=>
      pin_out_r[`PASL_BIT_COL] != strap_r[`PASL_BIT_COL])
    else $error("collision pin not asserted after collision");

  a_link_pin: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_driving |-> pin_out_r[`PASL_BIT_LINK] ==
      ($past(strap_r[`PASL_BIT_LINK]) ^ $past(link_up)))
    else $error("link pin wrong");

  a_tx_pin: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_driving |-> pin_out_r[`PASL_BIT_TX] ==
      ($past(strap_r[`PASL_BIT_TX]) ^ $past(tx_act)))
    else $error("transmit pin wrong");

  a_rx_pin: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_driving |-> pin_out_r[`PASL_BIT_RX] ==
      ($past(strap_r[`PASL_BIT_RX]) ^ $past(rx_act)))
    else $error("receive pin wrong");

  a_addr_frozen: assert property (
    @(posedge mclk) disable iff (!arst_n)
    in_drive |=> $stable(strap_r) && in_drive)
    else $error("address changed after sampling");

endmodule : pasl_top

/* verification/pasl_board_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Board side of the shared pins: one strap resistor and one LED per pin
// ----------------------------------------------------------------------------
module pasl_board_model #(
  parameter int unsigned PIN_CNT = 5          // Shared pins
) (
  input  wire logic [PIN_CNT-1:0] strap_cfg,  // Resistor rail, 1 = pull-up
  input  wire logic [PIN_CNT-1:0] pin_out,    // Device drive level
  input  wire logic [PIN_CNT-1:0] pin_oe,     // Device drive enable, high
  output logic      [PIN_CNT-1:0] pin_lvl,    // Resolved pad level
  output logic      [PIN_CNT-1:0] led_on      // LED lit
);
  // Undriven pad falls to its resistor rail, so no stale drive survives
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & strap_cfg);
  // Current only flows when the pad is driven away from its strap rail
  assign led_on  = pin_oe & (pin_out ^ strap_cfg);
endmodule : pasl_board_model

/* verification/phy_addr_strap_led_pins_tb.sv */
`timescale 1ns/1ps

module phy_addr_strap_led_pins_tb import pasl_pkg::*; ();
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  localparam int unsigned HOLD = 8;              // Shortened collision hold
  localparam logic [4:0]  STRAPS [4] = '{5'h0_0, 5'h1_F, 5'h1_5, 5'h0_A};
  logic       mclk, arst_n, sw_reset;            // Clock and resets
  logic       link_up, tx_act, rx_act, col_det;  // Status sources
  logic [4:0] strap_cfg, pin_in, pin_out;        // Board straps and pads
  logic [4:0] pin_oe, addr, led_on;              // Enables, address, LEDs
  int         miscompares, checks_done;          // Verdict counters

  pasl_top #(.PIN_CNT(5), .COL_HOLD_CYC(HOLD)) DUT (
    .mclk(mclk), .arst_n(arst_n), .sw_reset(sw_reset), .link_up(link_up),
    .tx_act(tx_act), .rx_act(rx_act), .col_det(col_det), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .management_station_address(addr));

  pasl_board_model #(.PIN_CNT(5)) board (
    .strap_cfg(strap_cfg), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_lvl(pin_in), .led_on(led_on));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Inputs always move 1 ns after the edge, never on it
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step

  task automatic cmp5(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp5

  // Expected indication vector in address bit order
  function automatic logic [4:0] ind_vec(logic lk, logic tx, logic rx, logic cl);
    pasl_ind_s e;
    e.rx   = rx;
    e.tx   = tx;
    e.link = lk;
    e.col  = cl;
    e.act  = rx | tx;
    return e;
  endfunction : ind_vec

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Hardware reset with a given strap, then release and sample
  task automatic t_strap(input logic [4:0] s);
    strap_cfg = s;
    arst_n    = 1'b0;
    repeat (10) step();
    cmp5(pin_oe, 5'h0_0);
    arst_n = 1'b1;
    step();
    cmp5(addr, s);
    cmp5(pin_oe, 5'h1_F);
    cmp5(pin_out, s);
    $display("strap test %h done", s);
  endtask : t_strap

  // Every link, transmit and receive combination
  task automatic t_ind(input logic [4:0] s);
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      {link_up, tx_act, rx_act} = c;
      repeat (2) step();
      cmp5(pin_out, s ^ ind_vec(c[2], c[1], c[0], 1'b0));
      cmp5(led_on, ind_vec(c[2], c[1], c[0], 1'b0));
      cmp5(addr, s);
    end
    {link_up, tx_act, rx_act} = 3'b000;
    repeat (2) step();
    $display("indication test %h done", s);
  endtask : t_ind

  // Single-cycle collision, retriggered mid-hold, exact hold length
  task automatic t_col(input logic [4:0] s);
    col_det = 1'b1;
    step();
    col_det = 1'b0;
    for (int i = 0; i < 3; i++) begin
      step();
      cmp5(pin_out, s ^ 5'h0_2);
    end
    col_det = 1'b1;
    step();
    col_det = 1'b0;
    for (int i = 0; i < HOLD; i++) begin
      step();
      cmp5(pin_out, s ^ 5'h0_2);
    end
    step();
    cmp5(pin_out, s);
    $display("collision test %h done", s);
  endtask : t_col

  // Software reset with the link up: only the link pin may move
  task automatic t_swrst(input logic [4:0] s);
    link_up  = 1'b1;
    sw_reset = 1'b1;
    for (int i = 0; i < 6; i++) begin
      step();
      cmp5(pin_oe, 5'h1_F);
      cmp5(addr, s);
      if (i > 0) cmp5(pin_out, s ^ 5'h0_4);
    end
    sw_reset = 1'b0;
    link_up  = 1'b0;
    repeat (2) step();
    cmp5(pin_out, s);
    $display("software reset test %h done", s);
  endtask : t_swrst

  // --------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Fixed-step scenarios cannot hang, but a stalled clock still could
  initial begin
    #1_000_000;
    miscompares++;
    $display("Watchdog expired");
    final_report();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    arst_n      = 1'b0;
    sw_reset    = 1'b0;
    link_up     = 1'b0;
    tx_act      = 1'b0;
    rx_act      = 1'b0;
    col_det     = 1'b0;
    strap_cfg   = 5'h0_0;
    foreach (STRAPS[k]) begin
      t_strap(STRAPS[k]);
      t_ind(STRAPS[k]);
      t_col(STRAPS[k]);
      t_swrst(STRAPS[k]);
    end
    final_report();
  end
endmodule : phy_addr_strap_led_pins_tb
